// File: tb/serial_parallel_latch_driver_test.sv
// bench: host end drives device end across the link, outputs scored
`timescale 1ns/1ns
`define CHK(nm, got, exp) begin n_tests++; if ((got) !== (exp)) begin \
   fails++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module serial_parallel_latch_driver_test;
   logic clk, link_clk, rstn, cfg_serial, cfg_direct, word_valid, word_ready;
   logic powerup_done;
   logic [1:0] cfg_pup;
   logic [5:0] word_in, drive_out_true, drive_out_inverted, exp_w;
   logic [5:0] exp_q[$];
   int fails = 0;
   int n_tests = 0;
   localparam logic [5:0] PUP_TBL [4] = '{6'h00, 6'h10, 6'h20, 6'h3F};
   spld_if spld_if_i ();
   spld_host spld_host_i (.clk(clk), .rstn(rstn), .pins(spld_if_i.host),
      .cfg_serial(cfg_serial), .cfg_direct(cfg_direct), .cfg_pup(cfg_pup),
      .word_in(word_in), .word_valid(word_valid), .word_ready(word_ready));
   spld_device #(.PUP_CYC(16)) spld_device_i (.link_clk(link_clk),
      .rstn(rstn), .pins(spld_if_i.device), .drive_out_true(drive_out_true),
      .drive_out_inverted(drive_out_inverted), .powerup_done(powerup_done));
   spld_checker #(.PUP_CYC(16)) spld_checker_i (.link_clk(link_clk),
      .rstn(rstn), .serial_mode(spld_if_i.serial_mode),
      .serial_data(spld_if_i.serial_data), .serial_clk(spld_if_i.serial_clk),
      .latch_strobe(spld_if_i.latch_strobe),
      .parallel_word_in(spld_if_i.parallel_word_in),
      .powerup_select_lo(spld_if_i.powerup_select_lo),
      .powerup_select_hi(spld_if_i.powerup_select_hi),
      .drive_out_true(drive_out_true), .drive_out_inverted(drive_out_inverted),
      .powerup_done(powerup_done));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // odd offset puts every other link clock rising edge on a clk rising edge
   initial begin
      link_clk = 1'b0;
      #1;
      forever #3 link_clk = ~link_clk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic pwr_up(input int sel, input int len);
      int k;
      rstn = 1'b0;
      cfg_pup = sel[1:0];
      repeat (len) @(negedge clk);
      rstn = 1'b1;
      for (k = 0; k < 200 && powerup_done !== 1'b1; k++) @(negedge clk);
      // a capture that never comes is a mismatch, not a silent pass
      `CHK("pup_done", powerup_done, 1'b1)
      repeat (4) @(negedge clk);
   endtask
   // two negedges first: ready falls on the posedge that takes valid, before the first
   task automatic send(input logic [5:0] w);
      int k;
      exp_q.push_back(w);
      word_in = w;
      word_valid = 1'b1;
      @(negedge clk);
      word_valid = 1'b0;
      @(negedge clk);
      for (k = 0; k < 600 && word_ready !== 1'b1; k++) @(negedge clk);
      `CHK("ready", word_ready, 1'b1)
   endtask
   always @(posedge word_ready) begin
      if (exp_q.size() > 0) begin
         exp_w = exp_q.pop_front();
         `CHK("word", drive_out_true, exp_w)
      end
   end
   initial begin
      void'($urandom(32'h80DE8DDA));
      {rstn, cfg_serial, cfg_direct, cfg_pup, word_in, word_valid} = '0;
      for (int i = 0; i < 4; i++) begin
         pwr_up(i, i == 0 ? 20 : 4);
         `CHK("pup", drive_out_true, PUP_TBL[i])
      end
      cfg_direct = 1'b1;
      pwr_up(3, 4);
      `CHK("pup_par", drive_out_true, 6'h00)
      cfg_direct = 1'b0;
      for (int m = 0; m < 2; m++) begin
         cfg_serial = (m == 0);
         repeat (8) @(negedge clk);
         send(6'h3F);
         send(6'h00);
         repeat (6) send(6'($urandom));
      end
      report_and_stop();
   end
   initial begin
      #60000;
      fails++;
      report_and_stop();
   end
endmodule

// File: tb/spld_checker.sv
// link-side assertions for the latch driver
`timescale 1ns/1ns
module spld_checker #(
   parameter int unsigned PUP_CYC = 16
) (
   input wire logic link_clk,
   input wire logic rstn,
   input wire logic serial_mode,
   input wire logic serial_data,
   input wire logic serial_clk,
   input wire logic latch_strobe,
   input wire logic [5:0] parallel_word_in,
   input wire logic powerup_select_lo,
   input wire logic powerup_select_hi,
   input wire logic [5:0] drive_out_true,
   input wire logic [5:0] drive_out_inverted,
   input wire logic powerup_done
);
   logic sck_q;
   logic [5:0] sh_q;
   logic [7:0] cyc_q;
   logic [5:0] pup_w;
   assign pup_w = powerup_select_hi ? (powerup_select_lo ? 6'h3F : 6'h20)
      : (powerup_select_lo ? 6'h10 : 6'h00);
   // reference register; one flop is enough, host holds data 13 cycles
   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) begin
         sck_q <= 1'b0;
         sh_q <= 6'h00;
         cyc_q <= 8'h00;
      end else begin
         sck_q <= serial_clk;
         cyc_q <= (cyc_q == 8'hFF) ? cyc_q : cyc_q + 8'h01;
         if (!serial_mode) sh_q <= parallel_word_in;
         else if (serial_clk && !sck_q && !latch_strobe)
            sh_q <= {sh_q[4:0], serial_data};
      end
   end
   default clocking @(posedge link_clk); endclocking
   default disable iff (!rstn);
   pair_compl_a: assert property (
      drive_out_inverted == ~drive_out_true) else $error("pair not inverse");
   hold_low_a: assert property (
      (powerup_done && !latch_strobe)[*6] |-> $stable(drive_out_true))
      else $error("outputs moved with strobe low");
   direct_follow_a: assert property (
      (powerup_done && !serial_mode && latch_strobe
      && $stable(parallel_word_in))[*6] |-> drive_out_true == parallel_word_in)
      else $error("outputs not following parallel inputs");
   serial_load_a: assert property (
      (powerup_done && serial_mode && latch_strobe)[*6]
      |-> drive_out_true == sh_q) else $error("serial word not loaded");
   pup_sel_a: assert property (
      $rose(powerup_done) && !latch_strobe |-> drive_out_true == pup_w)
      else $error("wrong select power-up word");
   pup_par_a: assert property (
      $rose(powerup_done) && latch_strobe |->
      drive_out_true == parallel_word_in) else $error("wrong power-up word");
   pup_time_a: assert property (
      $rose(powerup_done) |-> cyc_q + 8'h02 >= PUP_CYC && cyc_q <= PUP_CYC + 4)
      else $error("power-up capture off time");
   pre_pup_a: assert property (
      !powerup_done |-> drive_out_true == 6'h00) else $error("early update");
endmodule

// File: verilog/spld_device.sv
// driver end: input register, output latch, power-up select
// Overview of operation
// - serial path live only with mode high
// - host shifts six-bit word msb first
// - act on rising clock edges and strobe level
// - strobe high moves register to outputs
// - strobe high masks the serial clock
// - mode low loads register from parallel inputs
// - outputs hold while strobe stays low
// - strobe held high makes outputs follow
// - host sets inputs, then pulses strobe
// - serial clock period not below minimum
// - strobe pulse at least minimum width
// - strobe pulses spaced at least minimum
// - each output pair is complementary
// - strobe low at power-up: select word
// - strobe high at power-up: parallel word
`timescale 1ns/1ns
module spld_device
   import spld_pkg::*;
#(
   parameter int unsigned PUP_CYC = PUP_CYC_DEF
) (
   input wire logic link_clk,
   input wire logic rstn,
   spld_if.device pins,
   output logic [5:0] drive_out_true,
   output logic [5:0] drive_out_inverted,
   output logic powerup_done
);
   // all state; the link clock is a free-running sampling clock here
   typedef struct packed {
      logic [1:0] mode_s;
      logic [1:0] dat_s;
      logic [1:0] sck_s;
      logic [1:0] le_s;
      logic [1:0] pl_s;
      logic [1:0] ph_s;
      logic [5:0] par_s1;
      logic [5:0] par_s2;
      logic sck_prev;
      logic [5:0] shift;
      logic [5:0] outw;
      logic [CNT_W-1:0] pup_cnt;
      logic pup_done;
   } spld_dev_type;

   spld_dev_type s_q, s_d;
   logic mode, sdat, sck, le;

   assign mode = s_q.mode_s[1];
   assign sdat = s_q.dat_s[1];
   assign sck = s_q.sck_s[1];
   assign le = s_q.le_s[1];

   always_comb begin
      s_d = s_q;
      s_d.mode_s = {s_q.mode_s[0], pins.serial_mode};
      s_d.dat_s = {s_q.dat_s[0], pins.serial_data};
      s_d.sck_s = {s_q.sck_s[0], pins.serial_clk};
      s_d.le_s = {s_q.le_s[0], pins.latch_strobe};
      s_d.pl_s = {s_q.pl_s[0], pins.powerup_select_lo};
      s_d.ph_s = {s_q.ph_s[0], pins.powerup_select_hi};
      s_d.par_s1 = pins.parallel_word_in;
      s_d.par_s2 = s_q.par_s1;
      s_d.sck_prev = sck;
      if (!mode) begin
         // parallel load is level-driven, not clocked by the host
         s_d.shift = s_q.par_s2;
      end else if (sck && !s_q.sck_prev && !le) begin
         s_d.shift = {s_q.shift[4:0], sdat};
      end
      if (!s_q.pup_done) begin
         if (s_q.pup_cnt >= PUP_CYC - 1) begin
            s_d.pup_done = 1'b1;
            if (le) begin
               s_d.outw = s_q.par_s2;
            end else begin
               s_d.outw = spld_pup_word({s_q.ph_s[1], s_q.pl_s[1]});
            end
         end else begin
            s_d.pup_cnt = s_q.pup_cnt + 1'b1;
         end
      end else if (le) begin
         // level transparent: strobe held high tracks the register
         s_d.outw = s_q.shift;
      end
      // strobe low: outw keeps its value
   end

   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign drive_out_true = s_q.outw;
   assign drive_out_inverted = ~s_q.outw;
   assign powerup_done = s_q.pup_done;
endmodule

// File: verilog/spld_host.sv
// host end: serial word sender and parallel/strobe driver
`timescale 1ns/1ns
module spld_host
   import spld_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   spld_if.host pins,
   input wire logic cfg_serial,
   input wire logic cfg_direct,
   input wire logic [1:0] cfg_pup,
   input wire logic [5:0] word_in,
   input wire logic word_valid,
   output logic word_ready
);
   typedef struct packed {
      spld_state_type st;
      logic [5:0] sh;
      logic [2:0] bits;
      logic [7:0] cnt;
      logic sck;
      logic sdat;
      logic le;
      logic [5:0] par;
   } spld_host_type;

   spld_host_type s_q, s_d;

   always_comb begin
      s_d = s_q;
      case (s_q.st)
         SPLD_IDLE: begin
            s_d.le = cfg_direct && !cfg_serial;
            if (word_valid) begin
               s_d.le = 1'b0;
               s_d.cnt = 8'h00;
               if (cfg_serial) begin
                  s_d.sh = word_in;
                  s_d.sdat = word_in[5];
                  s_d.bits = BIT_CNT_RST;
                  s_d.st = SPLD_LOW;
               end else begin
                  s_d.par = word_in;
                  s_d.st = SPLD_HIGH;
               end
            end
         end
         SPLD_LOW: begin
            s_d.cnt = s_q.cnt + 8'h01;
            if (s_q.cnt == 8'(SCK_HALF_CYC - 1)) begin
               s_d.cnt = 8'h00;
               s_d.sck = 1'b1;
               s_d.st = SPLD_HIGH;
            end
         end
         SPLD_HIGH: begin
            // serial: clock high half; parallel: input settle time
            s_d.cnt = s_q.cnt + 8'h01;
            if (s_q.cnt == 8'(SCK_HALF_CYC - 1)) begin
               s_d.cnt = 8'h00;
               s_d.sck = 1'b0;
               if (cfg_serial && s_q.bits != 3'(WORD_W - 1)) begin
                  s_d.bits = s_q.bits + 3'h1;
                  s_d.sh = {s_q.sh[4:0], 1'b0};
                  s_d.sdat = s_q.sh[4];
                  s_d.st = SPLD_LOW;
               end else begin
                  s_d.le = 1'b1;
                  s_d.st = SPLD_LE_HI;
               end
            end
         end
         SPLD_LE_HI: begin
            // device samples through two flops, so hold well past min
            s_d.cnt = s_q.cnt + 8'h01;
            if (s_q.cnt == 8'(LE_WIDTH_CYC * 4 - 1)) begin
               s_d.cnt = 8'h00;
               s_d.le = 1'b0;
               s_d.st = SPLD_SPACE;
            end
         end
         SPLD_SPACE: begin
            s_d.cnt = s_q.cnt + 8'h01;
            if (s_q.cnt == 8'(LE_SPACE_CYC - 1)) begin
               s_d.cnt = 8'h00;
               s_d.st = SPLD_IDLE;
            end
         end
         default: s_d.st = SPLD_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign word_ready = (s_q.st == SPLD_IDLE);
   assign pins.serial_mode = cfg_serial;
   assign pins.serial_data = s_q.sdat;
   assign pins.serial_clk = s_q.sck;
   assign pins.latch_strobe = s_q.le;
   assign pins.parallel_word_in = s_q.par;
   assign pins.powerup_select_lo = cfg_pup[0];
   assign pins.powerup_select_hi = cfg_pup[1];
endmodule

// File: verilog/spld_if.sv
// pin-level link between host and driver
`timescale 1ns/1ns
interface spld_if;
   logic serial_mode;
   logic serial_data;
   logic serial_clk;
   logic latch_strobe;
   logic [5:0] parallel_word_in;
   logic powerup_select_lo;
   logic powerup_select_hi;
   modport device (
      input serial_mode, serial_data, serial_clk, latch_strobe,
      input parallel_word_in, powerup_select_lo, powerup_select_hi
   );
   modport host (
      output serial_mode, serial_data, serial_clk, latch_strobe,
      output parallel_word_in, powerup_select_lo, powerup_select_hi
   );
endinterface

// File: verilog/spld_pkg.sv
// shared constants and types for the serial/parallel latch driver
package spld_pkg;
   localparam int unsigned WORD_W = 6;
   localparam int unsigned CLK_MHZ = 250;
   // serial clock low and high half-periods, in host clock cycles
   localparam int unsigned SCK_PERIOD_NS = 100;
   localparam int unsigned SCK_HALF_CYC =
      (SCK_PERIOD_NS * CLK_MHZ + 1999) / 2000;
   localparam int unsigned LE_WIDTH_NS = 10;
   localparam int unsigned LE_WIDTH_CYC =
      (LE_WIDTH_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned LE_SPACE_NS = 630;
   localparam int unsigned LE_SPACE_CYC =
      (LE_SPACE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned PUP_TIME_MS = 200;
   localparam int unsigned PUP_CYC_DEF = PUP_TIME_MS * CLK_MHZ * 1000;
   localparam int unsigned CNT_W = 32;
   localparam logic [5:0] PUP_BIT4 = 6'h10;
   localparam logic [5:0] PUP_BIT5 = 6'h20;
   localparam logic [5:0] PUP_ALL = 6'h3F;
   localparam logic [5:0] PUP_NONE = 6'h00;
   localparam logic [2:0] BIT_CNT_RST = 3'h0;

   typedef enum logic [2:0] {
      SPLD_IDLE = 3'h0,
      SPLD_LOW = 3'h1,
      SPLD_HIGH = 3'h3,
      SPLD_LE_HI = 3'h2,
      SPLD_SPACE = 3'h6
   } spld_state_type;

   function automatic logic [5:0] spld_pup_word(input logic [1:0] sel);
      logic [5:0] w;
      w = PUP_NONE;
      case (sel)
         2'h1: w = PUP_BIT4;
         2'h2: w = PUP_BIT5;
         2'h3: w = PUP_ALL;
         default: w = PUP_NONE;
      endcase
      return w;
   endfunction
endpackage
